// >>> include/hid_defines.svh
// Purpose: Offsets, field positions, reset values of the host IRQ/DMA request block
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes:   Definitions only
`ifndef HID_DEFINES_SVH
`define HID_DEFINES_SVH

`define HID_ADDR_W        8
`define HID_OFS_MASK1     8'h00
`define HID_OFS_MASK2     8'h04
`define HID_OFS_STAT1     8'h08
`define HID_OFS_STAT2     8'h0c
`define HID_OFS_DIN       8'h10
`define HID_OFS_DOUT      8'h14
`define HID_OFS_REARM     8'h18
`define HID_OFS_EVT       8'h1c
`define HID_OFS_EVT_MASK  8'h20

`define HID_N_EV1         8
`define HID_N_EV2         5
`define HID_M2_DMA_IN     5
`define HID_M2_DMA_OUT    6
`define HID_S2_SUMMARY    7
`define HID_N_EVT         3
`define HID_EVT_TC        0
`define HID_EVT_DACK      1
`define HID_EVT_IRQ       2

`define HID_MASK1_RST     8'h00
`define HID_MASK2_RST     7'h00
`define HID_EVT_MASK_RST  3'h0

`endif

// >>> include/hid_pkg.sv
// Purpose: Types of the host IRQ/DMA request block
// Assumes: Widths fixed
// Notes:   Constants live in hid_defines.svh
package hid_pkg;

	// Bus-slave sequencing
	typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} hid_bus_state_t;

	// Events and flags from the bus protocol chip, same clock
	typedef struct packed {
		logic [7:0] ev_first;
		logic [4:0] ev_second;
		logic       data_in_ready_flag;
		logic       data_out_ready_flag;
	} hid_engine_t;

	// Host channel pins driven by the block
	typedef struct packed {
		logic irq;
		logic irq_oe;
		logic drq;
		logic drq_oe;
	} hid_pins_t;

endpackage

// >>> design/hid_sync3.sv
// Purpose: Three-flop synchroniser for asynchronous pins
// Assumes: Output changes only when the second and third flops agree
// Notes:   First flop feeds only the second
`timescale 1ns/100ps
module hid_sync3 #(
	parameter int         W       = 2,
	parameter logic [1:0] RST_VAL = 2'h0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					s1_q[i]   <= RST_VAL[i];
					s2_q[i]   <= RST_VAL[i];
					s3_q[i]   <= RST_VAL[i];
					sync_q[i] <= RST_VAL[i];
				end else if (clk_en) begin
					s1_q[i] <= async_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						sync_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate

endmodule

// >>> design/hid_irq_dma.sv
// Purpose: Host interrupt and DMA request logic of the instrument-bus adapter
// Assumes: Protocol chip events arrive on sys_clk; tc and dack_n are async pins
// Notes:   Registers reached over Avalon-MM with waitrequest
// Operation
// [RULE_01] A chip source requests an interrupt only when its mask bit is set.
// [RULE_02] IRQ pin is driven only while some interrupt enable bit is set.
// [RULE_03] With no enable bit set, the IRQ level stays high.
// [RULE_04] An asserted request holds until its status register is read.
// [RULE_05] Reading a status register clears all its bits.
// [RULE_06] Reading second then first status clears all thirteen causes.
// [RULE_07] A write to the re-arm address re-enables the IRQ output.
// [RULE_08] Handler reads second, first status, sends EOI, then writes re-arm.
// [RULE_09] Terminal-count interrupt needs a DMA direction enable and an interrupt enable.
// [RULE_10] Terminal-count pulse during a DMA transfer raises that interrupt.
// [RULE_11] Terminal-count interrupt has no status bit; second status read clears it.
// [RULE_12] DMA request follows data-in/data-out flags when its direction is enabled.
// [RULE_13] DRQ driven and DACK heeded only while a DMA direction is enabled.
// [RULE_14] DACK low clears the DMA request.
// [RULE_15] DMA request holds until a transfer, input read or output write.
// [RULE_16] Host DMA controller stays off while no direction is enabled.
// [RULE_17] Data-in flag means byte waiting; data-out flag means listeners ready.
// [RULE_18] Terminal-count pulse is synchronised and latched until second status read.
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "hid_defines.svh"
module hid_irq_dma (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic                     clk_en,
	// Avalon-MM slave
	input  wire logic [`HID_ADDR_W-1:0]   address,
	input  wire logic                     read,
	input  wire logic                     write,
	input  wire logic [31:0]              writedata,
	output logic      [31:0]              readdata,
	output logic                          waitrequest,
	// Protocol chip side
	input  wire hid_pkg::hid_engine_t     engine,
	input  wire logic [7:0]               din_byte,
	output logic                          din_read_q,
	output logic                          dout_write_q,
	output logic      [7:0]               dout_byte_q,
	// Host channel pins
	input  wire logic                     tc_pin,
	input  wire logic                     dack_n_pin,
	output hid_pkg::hid_pins_t            pins_q,
	// Block interrupt
	output logic                          sys_irq_q
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] pin_sync;
	logic       tc_s;
	logic       dack_n_s;
	logic       tc_prev_q;

	hid_sync3 #(.W(2), .RST_VAL(2'h2)) u_sync (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.async_in ({dack_n_pin, tc_pin}),
		.sync_q   (pin_sync)
	);

	assign tc_s     = pin_sync[0];
	assign dack_n_s = pin_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave

	hid_pkg::hid_bus_state_t bus_state_q;
	logic [7:0]              mask1_q;
	logic [6:0]              mask2_q;
	logic [7:0]              stat1_q;
	logic [4:0]              stat2_q;
	logic                    tc_pend_q;
	logic [2:0]              evt_q;
	logic [2:0]              evt_mask_q;
	logic                    summary;
	logic [31:0]             rd_mux;
	logic                    acc_rd;
	logic                    acc_wr;

	assign acc_rd = read && (bus_state_q == hid_pkg::BUS_ANSWER);
	assign acc_wr = write && (bus_state_q == hid_pkg::BUS_ANSWER);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (address)
			`HID_OFS_MASK1:    rd_mux[7:0] = mask1_q;
			`HID_OFS_MASK2:    rd_mux[6:0] = mask2_q;
			`HID_OFS_STAT1:    rd_mux[7:0] = stat1_q;
			`HID_OFS_STAT2:    rd_mux[7:0] = {summary, 2'h0, stat2_q};
			`HID_OFS_DIN:      rd_mux[7:0] = din_byte;
			`HID_OFS_EVT:      rd_mux[2:0] = evt_q;
			`HID_OFS_EVT_MASK: rd_mux[2:0] = evt_mask_q;
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait cycle, then the answer stands for one edge
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			bus_state_q <= hid_pkg::BUS_IDLE;
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else if (clk_en) begin
			case (bus_state_q)
				hid_pkg::BUS_IDLE: begin
					if (read || write) begin
						bus_state_q <= hid_pkg::BUS_ANSWER;
						waitrequest <= 1'b0;
						readdata    <= rd_mux;
					end
				end
				hid_pkg::BUS_ANSWER: begin
					bus_state_q <= hid_pkg::BUS_IDLE;
					waitrequest <= 1'b1;
				end
				default: begin
					bus_state_q <= hid_pkg::BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mask registers

	logic any_ie;
	logic dma_in_enable;
	logic dma_out_enable;
	logic dma_any;

	assign any_ie         = (|mask1_q) || (|mask2_q[`HID_N_EV2-1:0]);
	assign dma_in_enable  = mask2_q[`HID_M2_DMA_IN];
	assign dma_out_enable = mask2_q[`HID_M2_DMA_OUT];
	assign dma_any        = dma_in_enable || dma_out_enable;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mask1_q    <= `HID_MASK1_RST;
			mask2_q    <= `HID_MASK2_RST;
			evt_mask_q <= `HID_EVT_MASK_RST;
		end else if (clk_en && acc_wr) begin
			case (address)
				`HID_OFS_MASK1:    mask1_q    <= writedata[7:0];
				`HID_OFS_MASK2:    mask2_q    <= writedata[6:0];
				`HID_OFS_EVT_MASK: evt_mask_q <= writedata[2:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status, cleared on read; a new event wins over the clear

	logic rd_stat1;
	logic rd_stat2;
	logic tc_hit;

	assign rd_stat1 = acc_rd && (address == `HID_OFS_STAT1);
	assign rd_stat2 = acc_rd && (address == `HID_OFS_STAT2);
	assign summary  = (|(stat1_q & mask1_q)) || (|(stat2_q & mask2_q[`HID_N_EV2-1:0])); // RULE_01

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			stat1_q <= 8'h00;
			stat2_q <= 5'h00;
		end else if (clk_en) begin
			// Clear only what readdata reported, so an event caught during the wait cycle survives
			stat1_q <= (stat1_q & ~(rd_stat1 ? readdata[7:0] : 8'h00)) | engine.ev_first; // RULE_05
			stat2_q <= (stat2_q & ~(rd_stat2 ? readdata[4:0] : 5'h00)) | engine.ev_second; // RULE_06
		end
	end

	// Terminal count while the host acknowledges a transfer
	assign tc_hit = tc_s && !tc_prev_q && dma_any && any_ie && !dack_n_s; // RULE_09 RULE_10

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			tc_prev_q <= 1'b0;
			tc_pend_q <= 1'b0;
		end else if (clk_en) begin
			tc_prev_q <= tc_s;
			if (tc_hit) begin
				tc_pend_q <= 1'b1; // RULE_18
			end else if (rd_stat2) begin
				tc_pend_q <= 1'b0; // RULE_11
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// IRQ line with shared-level re-arm

	logic irq_req;
	logic arm_q;
	logic rearm_wr;

	assign irq_req  = summary || tc_pend_q; // RULE_04
	assign rearm_wr = acc_wr && (address == `HID_OFS_REARM);

	// After a request is withdrawn the line stays quiet until re-armed
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			arm_q <= 1'b1;
		end else if (clk_en) begin
			if (rearm_wr) begin
				arm_q <= 1'b1; // RULE_07
			end else if (pins_q.irq_oe && pins_q.irq && !irq_req) begin
				arm_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pins_q.irq    <= 1'b1;
			pins_q.irq_oe <= 1'b0;
		end else if (clk_en) begin
			pins_q.irq_oe <= any_ie; // RULE_02
			pins_q.irq    <= any_ie ? (irq_req && arm_q) : 1'b1; // RULE_03
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DMA request

	logic in_cond;
	logic out_cond;
	logic in_prev_q;
	logic out_prev_q;
	logic dack_act;
	logic drq_set;
	logic drq_clr;
	logic rd_din;
	logic wr_dout;

	assign in_cond  = dma_in_enable && engine.data_in_ready_flag; // RULE_17
	assign out_cond = dma_out_enable && engine.data_out_ready_flag;
	assign dack_act = dma_any && !dack_n_s; // RULE_13
	assign rd_din   = acc_rd && (address == `HID_OFS_DIN);
	assign wr_dout  = acc_wr && (address == `HID_OFS_DOUT);
	assign drq_set  = (in_cond && !in_prev_q) || (out_cond && !out_prev_q); // RULE_12
	assign drq_clr  = dack_act || (rd_din && dma_in_enable) || (wr_dout && dma_out_enable) || !dma_any; // RULE_14 RULE_15

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			in_prev_q     <= 1'b0;
			out_prev_q    <= 1'b0;
			pins_q.drq    <= 1'b0;
			pins_q.drq_oe <= 1'b0;
		end else if (clk_en) begin
			in_prev_q     <= in_cond;
			out_prev_q    <= out_cond;
			pins_q.drq_oe <= dma_any; // RULE_13 RULE_16
			if (drq_set) begin
				pins_q.drq <= 1'b1;
			end else if (drq_clr) begin
				pins_q.drq <= 1'b0;
			end
		end
	end

	// Data register strobes toward the protocol chip
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			din_read_q   <= 1'b0;
			dout_write_q <= 1'b0;
			dout_byte_q  <= 8'h00;
		end else if (clk_en) begin
			din_read_q   <= rd_din;
			dout_write_q <= wr_dout;
			if (wr_dout) begin
				dout_byte_q <= writedata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Block events, write one to clear, set wins

	logic [2:0] evt_set;
	logic [2:0] evt_clr;
	logic       irq_prev_q;

	assign evt_set = {pins_q.irq_oe && pins_q.irq && !irq_prev_q, dack_act && pins_q.drq, tc_hit};
	assign evt_clr = (acc_wr && (address == `HID_OFS_EVT)) ? writedata[2:0] : 3'h0;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			evt_q      <= 3'h0;
			irq_prev_q <= 1'b0;
			sys_irq_q  <= 1'b0;
		end else if (clk_en) begin
			irq_prev_q <= pins_q.irq_oe && pins_q.irq;
			evt_q      <= (evt_q & ~evt_clr) | evt_set;
			sys_irq_q  <= |(evt_q & evt_mask_q);
		end
	end

endmodule

// >>> tb/hid_irq_dma_checker.sv
// Purpose: Port assertions of hid_irq_dma
// Assumes: clk_en held high
// Notes:   Bound from the bench
`timescale 1ns/100ps
`include "hid_defines.svh"
module hid_irq_dma_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bus
	input wire logic [`HID_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Results
	input wire logic din_read_q,
	input wire logic dout_write_q,
	input wire hid_pkg::hid_pins_t pins_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	a_wait_one: assert property (!waitrequest |=> waitrequest)
		else $error("wait low too long");
	a_bus_take: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not taken");
	a_rd_stable: assert property (waitrequest && !read && !write |=> $stable(readdata))
		else $error("readdata moved");
	a_idle_high: assert property (!pins_q.irq_oe |-> pins_q.irq)
		else $error("irq low undriven");
	a_oe_follow: assert property (write && !waitrequest && address == `HID_OFS_MASK1 &&
		writedata[7:0] != 8'h00 |-> ##[1:2] pins_q.irq_oe) else $error("irq not driven");
	a_drq_oe: assert property (pins_q.drq |-> pins_q.drq_oe)
		else $error("drq undriven");
	a_din_pulse: assert property (read && !waitrequest && address == `HID_OFS_DIN |-> ##[1:2] din_read_q)
		else $error("no input read strobe");
	a_dout_pulse: assert property (write && !waitrequest && address == `HID_OFS_DOUT |-> ##[1:2] dout_write_q)
		else $error("no output write strobe");
endmodule

// >>> tb/hid_host_model.sv
// Purpose: Host board DMA controller facing the adapter
// Assumes: One byte per request, acknowledge held six cycles
// Notes:   tc_arm marks the terminal transfer
`timescale 1ns/100ps
module hid_host_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bench control
	input wire logic dma_on,
	input wire logic tc_arm,
	// Adapter pins
	input wire hid_pkg::hid_pins_t pins_q,
	output logic dack_n_pin,
	output logic tc_pin
);
	logic [2:0] hold_q;
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			hold_q <= 3'h0;
			dack_n_pin <= 1'b1;
			tc_pin <= 1'b0;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
			dack_n_pin <= (hold_q == 3'h1);
			tc_pin <= tc_pin && (hold_q != 3'h1);
		end else if (dma_on && pins_q.drq_oe && pins_q.drq) begin
			hold_q <= 3'h6;
			dack_n_pin <= 1'b0;
			tc_pin <= tc_arm;
		end
	end
endmodule

// >>> tb/hid_irq_dma_bench.sv
// Purpose: Self-checking bench of hid_irq_dma
// Assumes: clk_en held high
// Notes:   pin() packs {sys_irq, irq, irq_oe, drq, drq_oe}
`timescale 1ns/100ps
`include "hid_defines.svh"
module hid_irq_dma_bench;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, rd;
	logic waitrequest, din_read_q, dout_write_q, sys_irq_q, tc_pin, dack_n_pin;
	logic [7:0] dout_byte_q;
	hid_pkg::hid_engine_t eng = '0;
	hid_pkg::hid_pins_t pins_q;
	logic dma_on = 1'b0;
	logic tc_arm = 1'b0;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	always #5 sys_clk = ~sys_clk;
	hid_irq_dma uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .engine(eng),
		.din_byte(8'ha5), .din_read_q(din_read_q), .dout_write_q(dout_write_q), .dout_byte_q(dout_byte_q),
		.tc_pin(tc_pin), .dack_n_pin(dack_n_pin), .pins_q(pins_q), .sys_irq_q(sys_irq_q));
	hid_host_model host (.sys_clk(sys_clk), .reset_n(reset_n), .dma_on(dma_on), .tc_arm(tc_arm),
		.pins_q(pins_q), .dack_n_pin(dack_n_pin), .tc_pin(tc_pin));
	////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic pin(input logic [4:0] e);
		repeat (8) @(posedge sys_clk);
		cmp({27'h0, sys_irq_q, pins_q}, {27'h0, e});
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge sys_clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask
	task automatic pulse(input logic [7:0] f1, input logic [4:0] f2);
		@(posedge sys_clk);
		eng.ev_first <= f1;
		eng.ev_second <= f2;
		@(posedge sys_clk);
		eng.ev_first <= 8'h00;
		eng.ev_second <= 5'h00;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		pin(5'h08);
		pulse(8'h04, 5'h00);
		pin(5'h08);
		rdc(`HID_OFS_STAT1, 32'h4);
		rdc(`HID_OFS_STAT1, 32'h0);
		bus(1'b1, `HID_OFS_MASK1, 32'h04);
		pin(5'h04);
		pulse(8'h08, 5'h00);
		pin(5'h04);
		pulse(8'h04, 5'h00);
		pin(5'h0c);
		rdc(`HID_OFS_STAT2, 32'h80);
		pin(5'h0c);
		rdc(`HID_OFS_STAT1, 32'h0c);
		pin(5'h04);
		pulse(8'h04, 5'h00);
		pin(5'h04);
		bus(1'b1, `HID_OFS_REARM, 32'h0);
		pin(5'h0c);
		rdc(`HID_OFS_STAT1, 32'h04);
		bus(1'b1, `HID_OFS_REARM, 32'h0);
		bus(1'b1, `HID_OFS_MASK1, 32'hff);
		bus(1'b1, `HID_OFS_MASK2, 32'h1f);
		pulse(8'hff, 5'h1f);
		pin(5'h0c);
		rdc(`HID_OFS_STAT2, 32'h9f);
		pin(5'h0c);
		rdc(`HID_OFS_STAT1, 32'hff);
		pin(5'h04);
		bus(1'b1, `HID_OFS_REARM, 32'h0);
		bus(1'b1, `HID_OFS_MASK1, 32'h00);
		bus(1'b1, `HID_OFS_MASK2, 32'h21);
		pin(5'h05);
		eng.data_in_ready_flag <= 1'b1;
		pin(5'h07);
		rdc(`HID_OFS_DIN, 32'ha5);
		pin(5'h05);
		eng.data_in_ready_flag <= 1'b0;
		bus(1'b1, `HID_OFS_MASK2, 32'h20);
		pin(5'h09);
		dma_on <= 1'b1;
		tc_arm <= 1'b1;
		eng.data_in_ready_flag <= 1'b1;
		repeat (8) @(posedge sys_clk);
		pin(5'h09);
		eng.data_in_ready_flag <= 1'b0;
		bus(1'b1, `HID_OFS_MASK2, 32'h21);
		pin(5'h05);
		eng.data_in_ready_flag <= 1'b1;
		repeat (8) @(posedge sys_clk);
		pin(5'h0d);
		rdc(`HID_OFS_STAT2, 32'h0);
		pin(5'h05);
		eng.data_in_ready_flag <= 1'b0;
		dma_on <= 1'b0;
		bus(1'b1, `HID_OFS_MASK2, 32'h41);
		rdc(`HID_OFS_MASK2, 32'h41);
		pin(5'h05);
		eng.data_out_ready_flag <= 1'b1;
		pin(5'h07);
		bus(1'b1, `HID_OFS_DOUT, 32'h5a);
		pin(5'h05);
		cmp({24'h0, dout_byte_q}, 32'h5a);
		eng.data_out_ready_flag <= 1'b0;
		bus(1'b1, `HID_OFS_MASK2, 32'h00);
		pin(5'h08);
		rdc(8'h3c, 32'h0);
		bus(1'b1, `HID_OFS_EVT_MASK, 32'h1);
		rdc(`HID_OFS_EVT_MASK, 32'h1);
		rdc(`HID_OFS_EVT, 32'h7);
		pin(5'h18);
		bus(1'b1, `HID_OFS_EVT, 32'h7);
		pin(5'h08);
		rdc(`HID_OFS_EVT, 32'h0);
		close_out();
	end
endmodule
bind hid_irq_dma hid_irq_dma_checker chk (.sys_clk(sys_clk), .reset_n(reset_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.din_read_q(din_read_q), .dout_write_q(dout_write_q), .pins_q(pins_q));
